// ==== core/frsf_top.sv ====
// Receive far-end alarm code status, event flags, interrupt and code queue.
// Assumes the line-side processor delivers codes as one-cycle strobes on core_clk
// and that all inputs are synchronous to core_clk.
//
// Function
// R01 - Soft reset bit holds processor in reset, empties queue, drops incoming codes.
// R02 - Clearing soft reset bit resumes normal code collection.
// R03 - Queue empty status reads one when queue holds no code.
// R04 - Codeword status reads one while a valid code is being received.
// R05 - Idle status reads one while the all-ones idle signal is seen.
// R06 - Code arriving into a full queue is lost and sets overflow flag.
// R07 - Codeword flag sets on each rising edge of live codeword status.
// R08 - Idle flag sets on each rising edge of live idle status.
// R09 - Idle flag reads one directly after device reset.
// R10 - Interrupt when flag set, its enable set, and port global enable set.
// R11 - Queue word invalid bit is one when queue is empty.
// R12 - First received code bit lands in field bit 0, last in bit 5.
// R13 - Reading the queue word low byte pops the queue.
// R14 - Flags stay set until software writes one; zero leaves them.
// R15 - Queue depth chosen here; overflow when every entry occupied.
`timescale 1ns/1ps

module frsf_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [11:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire frsf_pkg::frsf_line_t line_in,
  input wire logic global_port_irq_enables,
  output logic rx_proc_reset,
  output logic irq
);

  logic [frsf_pkg::CODE_W-1:0] fifo_mem_q [frsf_pkg::FIFO_DEPTH];
  logic [frsf_pkg::CODE_W-1:0] fifo_mem_d [frsf_pkg::FIFO_DEPTH];
  logic [frsf_pkg::PTR_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [frsf_pkg::PTR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic [frsf_pkg::CNT_W-1:0] count_q, count_d;
  logic [15:0] control_q, control_d;
  frsf_pkg::frsf_events_t latched_q, latched_d;
  frsf_pkg::frsf_events_t enable_q, enable_d;
  logic idle_prev_q, idle_prev_d;
  logic codeword_prev_q, codeword_prev_d;
  logic [31:0] dat_r_d;
  logic ack_d;
  logic irq_d;
  logic soft_reset_d;

  // Combinational decode of the bus access and the live line state
  logic req;
  logic [9:0] idx;
  logic soft_reset;
  logic live_idle;
  logic live_codeword;
  logic empty;
  logic full;
  logic push;
  logic pop;
  logic overflow_evt;
  logic [15:0] live_word;
  logic [15:0] fifo_word;
  logic [15:0] rd_word;

  // A request is answered one cycle after it appears, then ack drops for a cycle
  assign req = wb_cyc & wb_stb & ~wb_ack;
  assign idx = wb_adr[11:2];
  assign soft_reset = control_q[frsf_pkg::CTRL_SOFT_RESET_BIT];
  // Live state is masked while the processor is held in reset
  assign live_idle = line_in.idle & ~soft_reset; // [R05] [R01]
  assign live_codeword = line_in.codeword & ~soft_reset; // [R04] [R01]
  assign empty = (count_q == '0); // [R03]
  assign full = (count_q == frsf_pkg::FIFO_FULL_COUNT); // [R15]
  // Pop only when the low byte of the queue word is read and a code is there
  assign pop = req & ~wb_we & wb_sel[0] & (idx == frsf_pkg::IDX_FIFO_DATA) & ~empty; // [R13]
  // A pop in the same cycle frees the slot, so a full queue still accepts
  assign push = line_in.code_valid & ~soft_reset & (~full | pop); // [R01] [R02]
  assign overflow_evt = line_in.code_valid & ~soft_reset & full & ~pop; // [R06]

  // Live status word
  always_comb begin
    live_word = 16'h0000;
    live_word[frsf_pkg::LIVE_IDLE_BIT] = live_idle; // [R05]
    live_word[frsf_pkg::LIVE_CODEWORD_BIT] = live_codeword; // [R04]
    live_word[frsf_pkg::LIVE_EMPTY_BIT] = empty; // [R03]
  end

  // Queue word: the head code, or zero code with invalid set when empty
  always_comb begin
    fifo_word = 16'h0000;
    if (empty) begin
      fifo_word[frsf_pkg::FIFO_INVALID_BIT] = 1'b1; // [R11]
    end else begin
      fifo_word[frsf_pkg::CODE_W-1:0] = fifo_mem_q[rd_ptr_q]; // [R12]
    end
  end

  // Read multiplexer; unmapped offsets answer with zero
  always_comb begin
    case (idx)
      frsf_pkg::IDX_CONTROL: rd_word = control_q;
      frsf_pkg::IDX_LIVE_STATUS: rd_word = live_word;
      frsf_pkg::IDX_LATCHED_STATUS: rd_word = {13'h0000, latched_q};
      frsf_pkg::IDX_IRQ_ENABLE: rd_word = {13'h0000, enable_q};
      frsf_pkg::IDX_FIFO_DATA: rd_word = fifo_word;
      default: rd_word = 16'h0000;
    endcase
  end

  // Next state of registers, flags, queue and bus answer
  always_comb begin
    frsf_pkg::frsf_events_t clr;
    frsf_pkg::frsf_events_t set;
    clr = '0;
    set = '0;
    control_d = control_q;
    enable_d = enable_q;
    fifo_mem_d = fifo_mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    ack_d = req;
    dat_r_d = wb_dat_r;
    if (req) begin
      dat_r_d = wb_we ? 32'h0000_0000 : {16'h0000, rd_word};
    end
    // Register writes honour the two low byte lanes
    if (req && wb_we) begin
      case (idx)
        frsf_pkg::IDX_CONTROL: begin
          if (wb_sel[0]) begin
            control_d[7:0] = wb_dat_w[7:0];
          end
          if (wb_sel[1]) begin
            control_d[15:8] = wb_dat_w[15:8];
          end
        end
        frsf_pkg::IDX_LATCHED_STATUS: begin
          if (wb_sel[0]) begin
            clr = wb_dat_w[2:0]; // [R14]
          end
        end
        frsf_pkg::IDX_IRQ_ENABLE: begin
          if (wb_sel[0]) begin
            enable_d = wb_dat_w[2:0];
          end
        end
        default: begin
        end
      endcase
    end
    // Events; a set in the same cycle as its clear wins
    set.idle = live_idle & ~idle_prev_q; // [R08]
    set.codeword = live_codeword & ~codeword_prev_q; // [R07]
    set.overflow = overflow_evt; // [R06]
    latched_d = (latched_q & ~clr) | set; // [R14]
    idle_prev_d = live_idle;
    codeword_prev_d = live_codeword;
    // Queue update; the arriving code is stored bit for bit, first bit in bit 0
    if (push) begin
      fifo_mem_d[wr_ptr_q] = line_in.code; // [R12]
      wr_ptr_d = wr_ptr_q + 4'h1;
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 4'h1; // [R13]
    end
    if (push && !pop) begin
      count_d = count_q + 5'h01;
    end else if (pop && !push) begin
      count_d = count_q - 5'h01;
    end
    // Soft reset empties the queue and keeps it empty while held
    if (soft_reset) begin
      wr_ptr_d = '0; // [R01]
      rd_ptr_d = '0;
      count_d = '0;
    end
    soft_reset_d = control_d[frsf_pkg::CTRL_SOFT_RESET_BIT]; // [R01] [R02]
    // Interrupt level follows the flags registered this cycle
    irq_d = (|(latched_d & enable_d)) & global_port_irq_enables; // [R10]
  end

  // State registers; clk_en low freezes everything
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      control_q <= frsf_pkg::CONTROL_RESET;
      latched_q <= frsf_pkg::LATCHED_RESET; // [R09]
      enable_q <= frsf_pkg::IRQ_ENABLE_RESET;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      idle_prev_q <= 1'b0;
      codeword_prev_q <= 1'b0;
      wb_ack <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      irq <= 1'b0;
      rx_proc_reset <= 1'b0;
      for (int i = 0; i < frsf_pkg::FIFO_DEPTH; i++) begin
        fifo_mem_q[i] <= '0;
      end
    end else if (clk_en) begin
      control_q <= control_d;
      latched_q <= latched_d;
      enable_q <= enable_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      idle_prev_q <= idle_prev_d;
      codeword_prev_q <= codeword_prev_d;
      wb_ack <= ack_d;
      wb_dat_r <= dat_r_d;
      irq <= irq_d;
      rx_proc_reset <= soft_reset_d;
      fifo_mem_q <= fifo_mem_d;
    end
  end

endmodule : frsf_top

// ==== core/frsf_pkg.sv ====
// Package for the receive far-end alarm code status and queue block.
// Assumes a 32-bit classic Wishbone bus; each register takes one aligned word.
package frsf_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CONTROL = 10'h0d0;
  localparam logic [9:0] IDX_LIVE_STATUS = 10'h0d4;
  localparam logic [9:0] IDX_LATCHED_STATUS = 10'h0d6;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0d8;
  localparam logic [9:0] IDX_FIFO_DATA = 10'h0dc;

  // Values after reset
  localparam logic [15:0] CONTROL_RESET = 16'h0800;
  localparam logic [2:0] LATCHED_RESET = 3'h1;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;

  // Field positions
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int LIVE_IDLE_BIT = 0;
  localparam int LIVE_CODEWORD_BIT = 1;
  localparam int LIVE_EMPTY_BIT = 3;
  localparam int EVT_IDLE_BIT = 0;
  localparam int EVT_CODEWORD_BIT = 1;
  localparam int EVT_OVERFLOW_BIT = 2;
  localparam int FIFO_INVALID_BIT = 7;

  // Code queue geometry
  localparam int CODE_W = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = 5'h10;

  // What the receive code processor delivers each cycle
  typedef struct packed {
    logic code_valid;
    logic [CODE_W-1:0] code;
    logic idle;
    logic codeword;
  } frsf_line_t;

  // Latched event flags, also the layout of the enable register
  typedef struct packed {
    logic overflow;
    logic codeword;
    logic idle;
  } frsf_events_t;

endpackage : frsf_pkg

// ==== test/frsf_assertions.sv ====
// Checker for the code status block; sees only the top-level ports.
// Assumes one clock domain and clk_en high while traffic runs.
`timescale 1ns/1ps
module frsf_assertions (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [11:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack,
  input wire frsf_pkg::frsf_line_t line_in,
  input wire logic global_port_irq_enables,
  input wire logic rx_proc_reset,
  input wire logic irq
);
  logic rd, live, fifo, lat, ctl;
  logic [2:0] rr;
  logic [15:0] r;
  // Read answers sorted by register
  assign rd = wb_ack && !wb_we;
  assign r = wb_dat_r[15:0];
  assign live = rd && wb_adr[11:2] == frsf_pkg::IDX_LIVE_STATUS;
  assign fifo = rd && wb_adr[11:2] == frsf_pkg::IDX_FIFO_DATA;
  assign lat = rd && wb_adr[11:2] == frsf_pkg::IDX_LATCHED_STATUS;
  assign ctl = wb_ack && wb_we && wb_sel[0] && wb_adr[11:2] == frsf_pkg::IDX_CONTROL;
  // History of the soft reset output, oldest in the top bit
  always_ff @(posedge core_clk) begin
    rr <= {rr[1:0], rx_proc_reset};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_ack_pulse: assert property (wb_cyc && wb_stb && !wb_ack && clk_en
    |=> wb_ack ##1 !wb_ack) else $error("ack not one cycle");
  a_soft_copy: assert property (ctl |=> rx_proc_reset == $past(wb_dat_w[0]))
    else $error("soft reset not following control");
  a_reset_live: assert property (live && rr[1:0] == 2'h3 |-> r[3:0] == 4'h8)
    else $error("live status set in soft reset");
  a_reset_queue: assert property (fifo && rr[1:0] == 2'h3 |-> r == 16'h0080)
    else $error("queue not empty in soft reset");
  a_invalid_word: assert property (fifo && r[7] |-> r == 16'h0080)
    else $error("invalid word carries data");
  a_irq_global: assert property (!$past(global_port_irq_enables) |-> !irq)
    else $error("irq without global enable");
  a_live_mirror: assert property (live && rr == 3'h0 && $past(resetn, 3) &&
    line_in[1:0] == $past(line_in[1:0], 3) |-> {r[0], r[1]} == line_in[1:0])
    else $error("live status off the line");
  a_flag_bits: assert property (lat |-> r[15:3] == 13'h0000)
    else $error("stray latched bits");
  c_pop: cover property (fifo && !r[7]);
  c_irq: cover property (irq);
  c_soft: cover property (live && rx_proc_reset);
endmodule : frsf_assertions

// ==== test/frsf_line_model.sv ====
// Line-side model: turns bench requests into code strobes and levels.
// Assumes requests change just after a rising core_clk edge.
`timescale 1ns/1ps
module frsf_line_model (
  input wire logic core_clk,
  input wire logic send,
  input wire logic [5:0] seq,
  input wire logic idle,
  input wire logic cw,
  output frsf_pkg::frsf_line_t line_out
);
  logic [5:0] c;
  // Seq holds the first bit leftmost; that bit lands in field bit 0
  assign c = {<<{seq}};
  // Field shows the inverse between strobes so stale codes never look valid
  always_ff @(posedge core_clk) begin
    line_out <= {send, send ? c : ~c, idle, cw};
  end
endmodule : frsf_line_model

// ==== test/frsf_top_tb.sv ====
// Bench: Wishbone tasks, line model and checks for the code status block.
// Assumes package, design, checker and line model are compiled first.
`timescale 1ns/1ps
bind frsf_top frsf_assertions u_frsf_assertions (.core_clk, .resetn, .clk_en, .wb_cyc,
  .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .line_in,
  .global_port_irq_enables, .rx_proc_reset, .irq);
module frsf_top_tb;
  logic core_clk = 1'h0, resetn = 1'h0, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
  logic gen = 1'h0, snd = 1'h0, idl = 1'h0, cw = 1'h0, wb_ack, irq, rx_proc_reset;
  logic [3:0] wb_sel = 4'h0;
  logic [5:0] seq = 6'h00, e;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_dat_w = 32'h0, wb_dat_r;
  frsf_pkg::frsf_line_t line_in;
  int errors = 0, n_tests = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  frsf_top u_frsf_top (.core_clk, .resetn, .clk_en(1'h1), .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .line_in, .global_port_irq_enables(gen),
    .rx_proc_reset, .irq);
  frsf_line_model u_frsf_line_model (.core_clk, .send(snd), .seq, .idle(idl), .cw,
    .line_out(line_in));
  // Compare and count
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_tests++;
    if (s !== x) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // One classic cycle; d is write data or the expected read value
  task automatic bus(input logic [11:0] a, input logic w, input logic [15:0] d);
    wb_adr <= a;
    wb_we <= w;
    wb_dat_w <= {16'h0000, d};
    wb_sel <= 4'h3;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    // Ack and read data are taken at the rising edge, before that edge's updates land
    do @(posedge core_clk); while (wb_ack !== 1'h1);
    if (!w) chk(wb_dat_r[15:0], d);
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge core_clk);
  endtask : bus
  // One code strobe, then time for it to land
  task automatic push(input logic [5:0] s);
    snd <= 1'h1;
    seq <= s;
    @(posedge core_clk);
    snd <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask : push
  // Irq is looked at mid-cycle, away from its update edge
  task automatic irq_is(input logic x);
    @(negedge core_clk);
    chk({15'h0000, irq}, {15'h0000, x});
    @(posedge core_clk);
  endtask : irq_is
  task automatic print_verdict();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) if (cyc++ == 3000) begin
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    bus(12'h340, 1'h0, 16'h0800);
    bus(12'h358, 1'h0, 16'h0001);
    bus(12'h350, 1'h0, 16'h0008);
    bus(12'h370, 1'h0, 16'h0080);
    bus(12'h344, 1'h0, 16'h0000);
    gen <= 1'h1;
    bus(12'h360, 1'h1, 16'h0001);
    irq_is(1'h1);
    bus(12'h358, 1'h1, 16'h0000);
    irq_is(1'h1);
    bus(12'h358, 1'h1, 16'h0001);
    irq_is(1'h0);
    idl <= 1'h1;
    repeat (4) @(posedge core_clk);
    gen <= 1'h0;
    bus(12'h350, 1'h0, 16'h0009);
    bus(12'h358, 1'h0, 16'h0001);
    irq_is(1'h0);
    gen <= 1'h1;
    cw <= 1'h1;
    repeat (4) @(posedge core_clk);
    bus(12'h350, 1'h0, 16'h000b);
    bus(12'h358, 1'h0, 16'h0003);
    irq_is(1'h1);
    bus(12'h358, 1'h1, 16'h0003);
    for (int i = 0; i < 17; i++) push(6'(i + 33));
    bus(12'h350, 1'h0, 16'h0003);
    bus(12'h358, 1'h0, 16'h0004);
    irq_is(1'h0);
    bus(12'h360, 1'h1, 16'h0004);
    irq_is(1'h1);
    for (int i = 0; i < 16; i++) begin
      e = {<<{6'(i + 33)}};
      bus(12'h370, 1'h0, {10'h000, e});
    end
    bus(12'h370, 1'h0, 16'h0080);
    push(6'h05);
    bus(12'h340, 1'h1, 16'h0801);
    push(6'h11);
    bus(12'h350, 1'h0, 16'h0008);
    bus(12'h370, 1'h0, 16'h0080);
    bus(12'h340, 1'h1, 16'h0800);
    push(6'h03);
    bus(12'h370, 1'h0, 16'h0030);
    print_verdict();
  end
endmodule : frsf_top_tb
